// file: design/kmw_pkg.sv
// Package with the register map, field positions and encodings of the wake and isolation block
package kmw_pkg;

  // Register byte offsets (low address byte decoded)
  localparam logic [7:0] OFF_WAKE_STS = 8'h10;
  localparam logic [7:0] OFF_WAKE_CLR = 8'h14;
  localparam logic [7:0] OFF_WAKE_EN = 8'h18;
  localparam logic [7:0] OFF_GLOBAL_WAKE = 8'h1C;
  localparam logic [7:0] OFF_CORE_RESET = 8'h2C;
  localparam logic [7:0] OFF_LATCH_ISO = 8'hF0;

  // Logical device that holds the latch and isolation register
  localparam logic [7:0] LATCH_ISO_LDEV = 8'h07;

  // Core reset register fields
  localparam int CORE_RST_BIT = 6;
  localparam logic [7:0] CORE_RST_RESET = 8'h00;

  // Latch and isolation register fields
  localparam int KBD_LATCH_SEL_BIT = 3;
  localparam int MOUSE_LATCH_SEL_BIT = 4;
  localparam int KBD_ISO_BIT = 5;
  localparam int MOUSE_ISO_BIT = 6;
  localparam logic [7:0] LATCH_ISO_RESET = 8'h00;

  // Wake status, clear and enable layout
  localparam int WAKE_W = 4;
  localparam int WAKE_KBD_IRQ = 0;
  localparam int WAKE_MOUSE_IRQ = 1;
  localparam int WAKE_KBD_DATA = 2;
  localparam int WAKE_MOUSE_DATA = 3;
  localparam logic [3:0] WAKE_STS_RESET = 4'h0;
  localparam logic [3:0] WAKE_EN_RESET = 4'h0;
  localparam int GLOBAL_WAKE_BIT = 0;
  localparam logic GLOBAL_WAKE_RESET = 1'b0;

  // Synchroniser lanes
  localparam int SYNC_W = 5;
  localparam int SY_KBD_CLK = 0;
  localparam int SY_KBD_DAT = 1;
  localparam int SY_MOUSE_CLK = 2;
  localparam int SY_MOUSE_DAT = 3;
  localparam int SY_MAIN_PWR = 4;
  // Lines idle high, so a reset value of one hides false edges at release
  localparam logic [4:0] SYNC_RESET = 5'h1F;

  // Level shown to the core on a blocked line (released open-drain level)
  localparam logic ISO_LEVEL = 1'b1;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Bus slave states
  typedef enum logic [3:0] {
    BUS_IDLE = 4'h1,
    BUS_WRITE = 4'h2,
    BUS_RD_WAIT = 4'h4,
    BUS_RD_DONE = 4'h8
  } kmw_bus_state_t;

endpackage

// file: design/kmw_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
module kmw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic hclk, // Block clock
  input wire logic hresetn, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Levels from outside the clock domain
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // kmw_sync

// file: design/kmw_irq_latch.sv
// Latch on one core interrupt with selectable output form
`timescale 1ns/1ns
module kmw_irq_latch (
  input wire logic hclk, // Block clock
  input wire logic hresetn, // Async reset, active low
  input wire logic raw_irq, // Interrupt from the controller core
  input wire logic latch_sel, // 0: raw AND latched, 1: latched alone
  output logic irq_out, // Registered interrupt toward the system
  output logic irq_rise // One-cycle pulse on a rising raw interrupt
);

  logic prev_ff;
  logic latched_ff;
  logic out_ff;

  assign irq_rise = raw_irq & ~prev_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= raw_irq;
    end
  end

  // Set on the rising edge, dropped as soon as the core lets go
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latched_ff <= 1'b0;
    end else if (!raw_irq) begin
      latched_ff <= 1'b0;
    end else if (irq_rise) begin
      latched_ff <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ff <= 1'b0;
    end else if (latch_sel) begin
      out_ff <= latched_ff;
    end else begin
      out_ff <= raw_irq & latched_ff;
    end
  end

  assign irq_out = out_ff;

endmodule // kmw_irq_latch

// file: design/kmw_top.sv
// Keyboard and mouse wake, interrupt latch and isolation glue with an AHB-Lite register slave
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
module kmw_top (
  input wire logic hclk, // Bus and block clock, 100 MHz
  input wire logic hresetn, // Async reset, active low
  // AHB-Lite slave
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data, registered
  // External lines
  input wire logic kbd_clock_line, // Keyboard clock pin level
  input wire logic kbd_data_line, // Keyboard data pin level
  input wire logic mouse_clock_line, // Mouse clock pin level
  input wire logic mouse_data_line, // Mouse data pin level
  input wire logic main_power_ok, // High while main power is present
  // Controller core side
  input wire logic core_kbd_irq, // Raw keyboard interrupt from the core
  input wire logic core_mouse_irq, // Raw mouse interrupt from the core
  output logic core_kbd_clock, // Keyboard clock into the core
  output logic core_kbd_data, // Keyboard data into the core
  output logic core_mouse_clock, // Mouse clock into the core
  output logic core_mouse_data, // Mouse data into the core
  output logic core_reset, // Holds the core in reset, active high
  // System side
  output logic kbd_irq, // Keyboard interrupt toward the system
  output logic mouse_irq, // Mouse interrupt toward the system
  output logic wake_pme // Power management event, level, active high
);

  kmw_pkg::kmw_bus_state_t state_ff;
  kmw_pkg::kmw_bus_state_t nxt_state;
  logic [7:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_mux;
  logic accept;
  logic wr_en;
  logic [7:0] core_reset_ff;
  logic [7:0] latch_iso_ff;
  logic [3:0] wake_sts_ff;
  logic [3:0] wake_en_ff;
  logic global_wake_ff;
  logic [3:0] wake_clr;
  logic [3:0] wake_set;
  logic [4:0] line_sync;
  logic kbd_dat_prev_ff;
  logic mouse_dat_prev_ff;
  logic kbd_dat_fall;
  logic mouse_dat_fall;
  logic kbd_rise;
  logic mouse_rise;
  logic main_pwr;
  logic kbd_iso;
  logic mouse_iso;
  logic core_kbd_clock_ff;
  logic core_kbd_data_ff;
  logic core_mouse_clock_ff;
  logic core_mouse_data_ff;
  logic pme_ff;

  // ---------------- Bus slave ----------------

  assign accept = hsel & hready & (htrans == kmw_pkg::HTRANS_NONSEQ);

  // Reads take one wait state so a read right after a write sees the new value
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      kmw_pkg::BUS_IDLE, kmw_pkg::BUS_WRITE, kmw_pkg::BUS_RD_DONE: begin
        if (accept) begin
          nxt_state = hwrite ? kmw_pkg::BUS_WRITE : kmw_pkg::BUS_RD_WAIT;
        end else begin
          nxt_state = kmw_pkg::BUS_IDLE;
        end
      end
      kmw_pkg::BUS_RD_WAIT: begin
        nxt_state = kmw_pkg::BUS_RD_DONE;
      end
      default: begin
        nxt_state = kmw_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= kmw_pkg::BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Upper address bits are not decoded, so the map repeats every 256 bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= 8'h00;
    end else if (accept) begin
      addr_ff <= haddr[7:0];
    end
  end

  assign wr_en = (state_ff == kmw_pkg::BUS_WRITE);
  assign hreadyout = (state_ff != kmw_pkg::BUS_RD_WAIT);
  assign hresp = kmw_pkg::HRESP_OKAY;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_ff)
      kmw_pkg::OFF_WAKE_STS: rd_mux = {28'h000_0000, wake_sts_ff};
      kmw_pkg::OFF_WAKE_EN: rd_mux = {28'h000_0000, wake_en_ff};
      kmw_pkg::OFF_GLOBAL_WAKE: rd_mux = {31'h0000_0000, global_wake_ff};
      kmw_pkg::OFF_CORE_RESET: rd_mux = {24'h00_0000, core_reset_ff};
      kmw_pkg::OFF_LATCH_ISO: rd_mux = {24'h00_0000, latch_iso_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (state_ff == kmw_pkg::BUS_RD_WAIT) begin
      hrdata_ff <= rd_mux;
    end
  end

  assign hrdata = hrdata_ff;

  // ---------------- Configuration registers ----------------

  // Stored whole byte; only bit 6 drives core_reset, so any write with bit 6 clear releases the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_reset_ff <= kmw_pkg::CORE_RST_RESET;
    end else if (wr_en && addr_ff == kmw_pkg::OFF_CORE_RESET) begin
      core_reset_ff <= hwdata[7:0];
    end
  end

  assign core_reset = core_reset_ff[kmw_pkg::CORE_RST_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_iso_ff <= kmw_pkg::LATCH_ISO_RESET;
    end else if (wr_en && addr_ff == kmw_pkg::OFF_LATCH_ISO) begin
      latch_iso_ff <= hwdata[7:0];
    end
  end

  assign kbd_iso = latch_iso_ff[kmw_pkg::KBD_ISO_BIT];
  assign mouse_iso = latch_iso_ff[kmw_pkg::MOUSE_ISO_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_en_ff <= kmw_pkg::WAKE_EN_RESET;
    end else if (wr_en && addr_ff == kmw_pkg::OFF_WAKE_EN) begin
      wake_en_ff <= hwdata[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_wake_ff <= kmw_pkg::GLOBAL_WAKE_RESET;
    end else if (wr_en && addr_ff == kmw_pkg::OFF_GLOBAL_WAKE) begin
      global_wake_ff <= hwdata[kmw_pkg::GLOBAL_WAKE_BIT];
    end
  end

  // ---------------- Line synchronisers and isolation ----------------

  kmw_sync #(
    .WIDTH(kmw_pkg::SYNC_W),
    .RESET_VAL(kmw_pkg::SYNC_RESET)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({main_power_ok, mouse_data_line, mouse_clock_line,
               kbd_data_line, kbd_clock_line}),
    .sync_out(line_sync)
  );

  assign main_pwr = line_sync[kmw_pkg::SY_MAIN_PWR];

  // Blocked lines show the idle level so the core sees no traffic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_kbd_clock_ff <= kmw_pkg::ISO_LEVEL;
      core_kbd_data_ff <= kmw_pkg::ISO_LEVEL;
    end else if (kbd_iso) begin
      core_kbd_clock_ff <= kmw_pkg::ISO_LEVEL;
      core_kbd_data_ff <= kmw_pkg::ISO_LEVEL;
    end else begin
      core_kbd_clock_ff <= line_sync[kmw_pkg::SY_KBD_CLK];
      core_kbd_data_ff <= line_sync[kmw_pkg::SY_KBD_DAT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_mouse_clock_ff <= kmw_pkg::ISO_LEVEL;
      core_mouse_data_ff <= kmw_pkg::ISO_LEVEL;
    end else if (mouse_iso) begin
      core_mouse_clock_ff <= kmw_pkg::ISO_LEVEL;
      core_mouse_data_ff <= kmw_pkg::ISO_LEVEL;
    end else begin
      core_mouse_clock_ff <= line_sync[kmw_pkg::SY_MOUSE_CLK];
      core_mouse_data_ff <= line_sync[kmw_pkg::SY_MOUSE_DAT];
    end
  end

  assign core_kbd_clock = core_kbd_clock_ff;
  assign core_kbd_data = core_kbd_data_ff;
  assign core_mouse_clock = core_mouse_clock_ff;
  assign core_mouse_data = core_mouse_data_ff;

  // ---------------- Interrupt latches ----------------

  kmw_irq_latch u_kbd_latch (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw_irq(core_kbd_irq),
    .latch_sel(latch_iso_ff[kmw_pkg::KBD_LATCH_SEL_BIT]),
    .irq_out(kbd_irq),
    .irq_rise(kbd_rise)
  );

  kmw_irq_latch u_mouse_latch (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw_irq(core_mouse_irq),
    .latch_sel(latch_iso_ff[kmw_pkg::MOUSE_LATCH_SEL_BIT]),
    .irq_out(mouse_irq),
    .irq_rise(mouse_rise)
  );

  // ---------------- Wake detection ----------------

  // Taps the synchronised pins ahead of the isolation gates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kbd_dat_prev_ff <= 1'b1;
      mouse_dat_prev_ff <= 1'b1;
    end else begin
      kbd_dat_prev_ff <= line_sync[kmw_pkg::SY_KBD_DAT];
      mouse_dat_prev_ff <= line_sync[kmw_pkg::SY_MOUSE_DAT];
    end
  end

  // Falling edge is the active edge: a start bit pulls data low
  assign kbd_dat_fall = kbd_dat_prev_ff & ~line_sync[kmw_pkg::SY_KBD_DAT];
  assign mouse_dat_fall = mouse_dat_prev_ff & ~line_sync[kmw_pkg::SY_MOUSE_DAT];

  always_comb begin
    wake_set = 4'h0;
    wake_set[kmw_pkg::WAKE_KBD_IRQ] = kbd_rise & main_pwr;
    wake_set[kmw_pkg::WAKE_MOUSE_IRQ] = mouse_rise & main_pwr;
    wake_set[kmw_pkg::WAKE_KBD_DATA] = kbd_dat_fall;
    wake_set[kmw_pkg::WAKE_MOUSE_DATA] = mouse_dat_fall;
  end

  assign wake_clr = (wr_en && addr_ff == kmw_pkg::OFF_WAKE_CLR) ? hwdata[3:0] : 4'h0;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_sts_ff <= kmw_pkg::WAKE_STS_RESET;
    end else begin
      wake_sts_ff <= (wake_sts_ff & ~wake_clr) | wake_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pme_ff <= 1'b0;
    end else begin
      pme_ff <= global_wake_ff & (|(wake_sts_ff & wake_en_ff));
    end
  end

  assign wake_pme = pme_ff;

endmodule // kmw_top

// file: test/kmw_top_props.sv
// Concurrent checks on the ports of the wake and isolation block
`timescale 1ns/1ns
module kmw_top_props (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready
  input wire logic kbd_data_line, // Keyboard data pin
  input wire logic mouse_clock_line, // Mouse clock pin
  input wire logic core_kbd_irq, // Raw keyboard irq
  input wire logic core_mouse_irq, // Raw mouse irq
  input wire logic core_kbd_clock, // Core keyboard clock
  input wire logic core_kbd_data, // Core keyboard data
  input wire logic core_mouse_clock, // Core mouse clock
  input wire logic core_mouse_data, // Core mouse data
  input wire logic core_reset, // Core reset
  input wire logic kbd_irq, // Keyboard irq out
  input wire logic mouse_irq, // Mouse irq out
  input wire logic wake_pme // Wake event
);
  logic wr_ff;
  logic [7:0] wa_ff;
  logic kiso_ff;
  logic miso_ff;
  logic glob_ff;
  logic rst_wr;
  assign rst_wr = wr_ff && wa_ff == kmw_pkg::OFF_CORE_RESET;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      wa_ff <= 8'h00;
    end else if (hready) begin
      wr_ff <= hsel && hwrite && htrans == kmw_pkg::HTRANS_NONSEQ;
      wa_ff <= haddr[7:0];
    end
  end
  // Shadow of the control bits, so port checks know the mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kiso_ff <= 1'b0;
      miso_ff <= 1'b0;
      glob_ff <= 1'b0;
    end else if (wr_ff && wa_ff == kmw_pkg::OFF_LATCH_ISO) begin
      kiso_ff <= hwdata[5];
      miso_ff <= hwdata[6];
    end else if (wr_ff && wa_ff == kmw_pkg::OFF_GLOBAL_WAKE) begin
      glob_ff <= hwdata[0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_kbd_latch_rise: assert property ($rose(core_kbd_irq) ##0 core_kbd_irq [*3] |-> ##[0:1] kbd_irq)
    else $error("keyboard irq not raised");
  a_mouse_latch_rise: assert property ($rose(core_mouse_irq) ##0 core_mouse_irq [*3] |-> ##[0:1] mouse_irq)
    else $error("mouse irq not raised");
  a_kbd_irq_cause: assert property (kbd_irq |-> $past(core_kbd_irq) || $past(core_kbd_irq, 2))
    else $error("keyboard irq without raw irq");
  a_core_rst_write: assert property ($changed(core_reset) |-> $past(rst_wr) && core_reset == $past(hwdata[6]))
    else $error("core reset changed without write");
  a_kbd_iso_hold: assert property (kiso_ff && $past(kiso_ff) |-> core_kbd_clock && core_kbd_data)
    else $error("keyboard lines not blocked");
  a_mouse_iso_hold: assert property (miso_ff && $past(miso_ff) |-> core_mouse_clock && core_mouse_data)
    else $error("mouse lines not blocked");
  a_kbd_data_pass: assert property (!kiso_ff [*4] |-> core_kbd_data == $past(kbd_data_line, 3))
    else $error("keyboard data not passed");
  a_mouse_clk_pass: assert property (!miso_ff [*4] |-> core_mouse_clock == $past(mouse_clock_line, 3))
    else $error("mouse clock not passed");
  a_pme_global_gate: assert property (wake_pme |-> $past(glob_ff))
    else $error("wake event without global enable");
endmodule // kmw_top_props
bind kmw_top kmw_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .kbd_data_line(kbd_data_line), .mouse_clock_line(mouse_clock_line),
  .core_kbd_irq(core_kbd_irq), .core_mouse_irq(core_mouse_irq), .core_kbd_clock(core_kbd_clock),
  .core_kbd_data(core_kbd_data), .core_mouse_clock(core_mouse_clock),
  .core_mouse_data(core_mouse_data), .core_reset(core_reset), .kbd_irq(kbd_irq),
  .mouse_irq(mouse_irq), .wake_pme(wake_pme));

// file: test/kmw_dev_model.sv
// Keyboard and mouse device model driving the external clock and data lines
`timescale 1ns/1ns
module kmw_dev_model (
  output logic kbd_clock_line, // Keyboard clock
  output logic kbd_data_line, // Keyboard data
  output logic mouse_clock_line, // Mouse clock
  output logic mouse_data_line // Mouse data
);
  // Released lines sit at the pull-up level
  initial begin
    kbd_clock_line = 1'b1;
    kbd_data_line = 1'b1;
    mouse_clock_line = 1'b1;
    mouse_data_line = 1'b1;
  end
  // Offset keeps edges away from the block clock edge
  task automatic set_data(input logic m, input logic v);
    #3;
    if (m)
      mouse_data_line = v;
    else
      kbd_data_line = v;
  endtask
  // Link clock runs only within a frame, 160 ns period
  task automatic frame(input logic m);
    set_data(m, 1'b0);
    for (int i = 0; i < 3; i++) begin
      #80;
      if (m)
        mouse_clock_line = 1'b0;
      else
        kbd_clock_line = 1'b0;
      #80;
      if (m)
        mouse_clock_line = 1'b1;
      else
        kbd_clock_line = 1'b1;
    end
    set_data(m, 1'b1);
  endtask
endmodule // kmw_dev_model

// file: test/kmw_top_tb.sv
// Self-checking testbench of the wake and isolation block
`timescale 1ns/1ns
module kmw_top_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hready;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic core_kbd_irq = 1'b0;
  logic core_mouse_irq = 1'b0;
  logic main_power_ok = 1'b1;
  logic hreadyout, hresp, kbd_clk_pin, kbd_dat_pin, mouse_clk_pin, mouse_dat_pin;
  logic core_kbd_clock, core_kbd_data, core_mouse_clock, core_mouse_data;
  logic core_reset, kbd_irq, mouse_irq, wake_pme;
  logic [31:0] hrdata;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  kmw_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .kbd_clock_line(kbd_clk_pin), .kbd_data_line(kbd_dat_pin),
    .mouse_clock_line(mouse_clk_pin), .mouse_data_line(mouse_dat_pin),
    .main_power_ok(main_power_ok),
    .core_kbd_irq(core_kbd_irq), .core_mouse_irq(core_mouse_irq),
    .core_kbd_clock(core_kbd_clock), .core_kbd_data(core_kbd_data),
    .core_mouse_clock(core_mouse_clock), .core_mouse_data(core_mouse_data),
    .core_reset(core_reset), .kbd_irq(kbd_irq), .mouse_irq(mouse_irq), .wake_pme(wake_pme));
  kmw_dev_model dev (.kbd_clock_line(kbd_clk_pin), .kbd_data_line(kbd_dat_pin),
    .mouse_clock_line(mouse_clk_pin), .mouse_data_line(mouse_dat_pin));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Single word transfer; waits on hready at each phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= kmw_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic t_regs;
    rd_chk(kmw_pkg::OFF_CORE_RESET, 32'h0);
    rd_chk(kmw_pkg::OFF_LATCH_ISO, 32'h0);
    rd_chk(kmw_pkg::OFF_WAKE_EN, 32'h0);
    rd_chk(kmw_pkg::OFF_GLOBAL_WAKE, 32'h0);
    rd_chk(kmw_pkg::OFF_WAKE_CLR, 32'h0);
    check(32'(hresp), 32'(kmw_pkg::HRESP_OKAY));
    bus(1'b1, 8'h40, 32'hFF);
    rd_chk(8'h40, 32'h0);
    bus(1'b1, kmw_pkg::OFF_LATCH_ISO, 32'h78);
    rd_chk(kmw_pkg::OFF_LATCH_ISO, 32'h78);
    bus(1'b1, kmw_pkg::OFF_LATCH_ISO, 32'h0);
  endtask
  task automatic t_core_reset;
    bus(1'b1, kmw_pkg::OFF_CORE_RESET, 32'h40);
    wait_n(2);
    check(32'(core_reset), 32'h1);
    wait_n(20);
    check(32'(core_reset), 32'h1);
    rd_chk(kmw_pkg::OFF_CORE_RESET, 32'h40);
    bus(1'b1, kmw_pkg::OFF_CORE_RESET, 32'h0);
    wait_n(2);
    check(32'(core_reset), 32'h0);
  endtask
  task automatic t_irq(input logic m, input logic sel, input logic pwr);
    bus(1'b1, kmw_pkg::OFF_LATCH_ISO, 32'(sel) << (m ? 4 : 3));
    bus(1'b1, kmw_pkg::OFF_WAKE_CLR, 32'hF);
    @(posedge hclk);
    if (m)
      core_mouse_irq <= 1'b1;
    else
      core_kbd_irq <= 1'b1;
    wait_n(5);
    check(32'(m ? mouse_irq : kbd_irq), 32'h1);
    core_mouse_irq <= 1'b0;
    core_kbd_irq <= 1'b0;
    wait_n(4);
    check(32'(m ? mouse_irq : kbd_irq), 32'h0);
    rd_chk(kmw_pkg::OFF_WAKE_STS, pwr ? (m ? 32'h2 : 32'h1) : 32'h0);
  endtask
  task automatic t_data_wake;
    dev.frame(1'b0);
    wait_n(6);
    rd_chk(kmw_pkg::OFF_WAKE_STS, 32'h4);
    dev.frame(1'b1);
    wait_n(6);
    rd_chk(kmw_pkg::OFF_WAKE_STS, 32'hC);
    bus(1'b1, kmw_pkg::OFF_WAKE_CLR, 32'h4);
    rd_chk(kmw_pkg::OFF_WAKE_STS, 32'h8);
    bus(1'b1, kmw_pkg::OFF_WAKE_CLR, 32'h8);
    rd_chk(kmw_pkg::OFF_WAKE_STS, 32'h0);
  endtask
  task automatic t_pme;
    bus(1'b1, kmw_pkg::OFF_WAKE_EN, 32'h4);
    dev.frame(1'b0);
    wait_n(6);
    check(32'(wake_pme), 32'h0);
    bus(1'b1, kmw_pkg::OFF_GLOBAL_WAKE, 32'h1);
    wait_n(3);
    check(32'(wake_pme), 32'h1);
    bus(1'b1, kmw_pkg::OFF_WAKE_EN, 32'h8);
    wait_n(3);
    check(32'(wake_pme), 32'h0);
    bus(1'b1, kmw_pkg::OFF_WAKE_EN, 32'h4);
    bus(1'b1, kmw_pkg::OFF_WAKE_CLR, 32'h4);
    wait_n(3);
    check(32'(wake_pme), 32'h0);
    rd_chk(kmw_pkg::OFF_WAKE_EN, 32'h4);
  endtask
  task automatic t_iso;
    bus(1'b1, kmw_pkg::OFF_LATCH_ISO, 32'h60);
    dev.set_data(1'b0, 1'b0);
    dev.set_data(1'b1, 1'b0);
    wait_n(6);
    check(32'({core_kbd_clock, core_kbd_data}), 32'h3);
    check(32'({core_mouse_clock, core_mouse_data}), 32'h3);
    rd_chk(kmw_pkg::OFF_WAKE_STS, 32'hC);
    bus(1'b1, kmw_pkg::OFF_LATCH_ISO, 32'h0);
    wait_n(6);
    check(32'({core_kbd_data, core_mouse_data}), 32'h0);
    dev.set_data(1'b0, 1'b1);
    dev.set_data(1'b1, 1'b1);
    wait_n(6);
    check(32'({core_kbd_data, core_mouse_data}), 32'h3);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_core_reset();
    for (int i = 0; i < 4; i++)
      t_irq(i[1], i[0], 1'b1);
    // Isolation set before main power goes away; t_core_reset then resets the core on return
    bus(1'b1, kmw_pkg::OFF_LATCH_ISO, 32'h60);
    main_power_ok <= 1'b0;
    wait_n(5);
    t_irq(1'b0, 1'b1, 1'b0);
    t_data_wake();
    main_power_ok <= 1'b1;
    wait_n(5);
    t_core_reset();
    t_pme();
    t_iso();
    tally_and_finish();
  end
endmodule // kmw_top_tb
